// *** mgh_top.sv ***
// Gate output conditioning and Hall front end with a Wishbone register slave.
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module mgh_top
  import mgh_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone slave.
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [5:0] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]     dat_o,
  output logic            ack_o,
  // Gate pins, enable low drives.
  output logic [5:0]      gate_o,
  output logic [5:0]      gate_oe_n_o,
  // Hall inputs.
  input  wire logic [2:0] hall_sensor_inputs_i,
  input  wire logic [2:0] hall_alt_inputs_i,
  // Hall result and delay timer.
  output logic [2:0]      hall_out_o,
  output logic            timer_run_bit_o,
  output logic [1:0]      delay_timer_select_o,
  input  wire logic       timer_match_i
);

  mgh_dead_cfg_t dead_time_setup_ff;
  logic [5:0]    output_polarity_ctrl_ff;
  logic [5:0]    predrive_ff;
  logic [7:0]    hmode_ff;
  logic [3:0]    filt_ff;
  logic [4:0]    check_ff;
  logic [2:0]    clk_div_ff;
  logic          tick;
  logic [5:0]    safe_req;
  logic [5:0]    dead_out;
  logic [2:0]    hall_sel;
  logic [2:0]    hall_filt;
  logic [2:0]    hall_src;
  logic [2:0]    delay_buffer_one_ff;
  logic [2:0]    delay_buffer_two_ff;
  logic          wr;
  logic [3:0]    word;
  logic [7:0]    rd;

  assign word = adr_i[5:2];
  assign wr   = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dead_time_setup_ff      <= DEAD_RST;
      output_polarity_ctrl_ff <= POL_RST[5:0];
      predrive_ff             <= 6'h00;
      hmode_ff                <= 8'h00;
      filt_ff                 <= 4'h0;
      check_ff                <= 5'h00;
    end
    else if (wr)
    begin
      if (word == ADR_DEAD)
        dead_time_setup_ff <= dat_i[7:0];
      else if (word == ADR_POL)
        output_polarity_ctrl_ff <= dat_i[5:0];
      else if (word == ADR_DRIVE)
        predrive_ff <= dat_i[5:0];
      else if (word == ADR_HMODE)
        hmode_ff <= dat_i[7:0];
      else if (word == ADR_FILT)
        filt_ff <= dat_i[3:0];
      else if (word == ADR_CHECK)
        check_ff <= dat_i[4:0];
    end
  end

  always_comb
  begin
    rd = 8'h00;
    if (word == ADR_DEAD)
      rd = dead_time_setup_ff;
    else if (word == ADR_POL)
      rd = {2'b00, output_polarity_ctrl_ff};
    else if (word == ADR_DRIVE)
      rd = {2'b00, predrive_ff};
    else if (word == ADR_HMODE)
      rd = hmode_ff;
    else if (word == ADR_FILT)
      rd = {4'h0, filt_ff};
    else if (word == ADR_CHECK)
      rd = {3'b000, check_ff};
    else if (word == ADR_STATUS)
      rd = {hall_out_o, delay_buffer_one_ff, timer_run_bit_o, 1'b0};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (cyc_i && stb_i && !we_i && !ack_o)
      dat_o <= {24'h00_0000, rd};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clk_div_ff <= 3'h0;
    else
      clk_div_ff <= clk_div_ff + 3'h1;
  end
  assign tick = div_tick(dead_time_setup_ff.div_sel, clk_div_ff);

  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_pair
      assign safe_req[2*p]   = predrive_ff[2*p] && !predrive_ff[2*p+1];
      assign safe_req[2*p+1] = predrive_ff[2*p+1] && !predrive_ff[2*p];
    end
    for (p = 0; p < 6; p++)
    begin : g_dead
      mgh_dead_chan u_dead (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cfg_i  (dead_time_setup_ff),
        .tick_i (tick),
        .req_i  (safe_req[p]),
        .drv_o  (dead_out[p])
      );
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gate_o      <= 6'h00;
      gate_oe_n_o <= 6'h3F;
    end
    else
    begin
      gate_o      <= dead_out ^ output_polarity_ctrl_ff;
      gate_oe_n_o <= {6{~hmode_ff[HM_OUT_BIT]}};
    end
  end

  assign hall_sel = hmode_ff[HM_SEL_BIT] ? hall_alt_inputs_i : hall_sensor_inputs_i;

  mgh_hall_filt u_filt (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .rate_i (filt_ff[2:0]),
    .need_i (check_ff),
    .raw_i  (hall_sel),
    .filt_o (hall_filt)
  );

  // Source mode chooses soft or sensor.
  assign hall_src = !hmode_ff[HM_SRC_BIT] ? hmode_ff[HM_SOFT_LSB +: 3] :
                    (filt_ff[FL_EN_BIT] ? hall_filt : hall_sel);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !hmode_ff[HM_DLY_BIT])
    begin
      delay_buffer_one_ff <= 3'h0;
      delay_buffer_two_ff <= 3'h0;
      timer_run_bit_o     <= 1'b0;
    end
    else
    begin
      // Hardware runs timer on a Hall change.
      if (hall_src != delay_buffer_one_ff)
      begin
        delay_buffer_one_ff <= hall_src;
        timer_run_bit_o     <= 1'b1;
      end
      else if (timer_run_bit_o && timer_match_i)
      begin
        delay_buffer_two_ff <= delay_buffer_one_ff;
        timer_run_bit_o     <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hall_out_o           <= 3'h0;
      delay_timer_select_o <= 2'h0;
    end
    else
    begin
      hall_out_o           <= hmode_ff[HM_DLY_BIT] ? delay_buffer_two_ff : hall_src;
      delay_timer_select_o <= hmode_ff[7 -: 1] == 1'b1 ? 2'h1 : 2'h0;
    end
  end

  a_pair_never_both: assert property (@(posedge clk_i) disable iff (rst_i)
    !(dead_out[0] && dead_out[1]))
    else $error("Phase A pair both on.");

  a_polarity_applied: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> gate_o == ($past(dead_out) ^ $past(output_polarity_ctrl_ff)))
    else $error("Gate polarity mismatch.");

  a_reset_float: assert property (@(posedge clk_i)
    rst_i |=> gate_oe_n_o == 6'h3F)
    else $error("Gate pins driven after reset.");

  a_buffers_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !hmode_ff[HM_DLY_BIT] |=> delay_buffer_one_ff == 3'h0 && delay_buffer_two_ff == 3'h0)
    else $error("Delay buffers not cleared.");

  a_timer_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !hmode_ff[HM_DLY_BIT] |=> !timer_run_bit_o)
    else $error("Timer run while delay off.");

endmodule : mgh_top

// *** mgh_pkg.sv ***
// Package with register map, field layout, states and carriers of the motor gate block.
// Notes on behaviour
// - Rising predrive edge waits the dead interval.
// - Falling predrive edge passes through at once.
// - Dead clock is system clock over 1/2/4/8.
// - Dead enable off delays rising edges by one clock only.
// - Dead interval is count plus one ticks.
// - Both drives of a pair on forces off.
// - Drive one means transistor on, zero off.
// - Six polarity bits invert the gate pins.
// - Gate pins float after reset.
// - Source mode picks soft bits or sensors.
// - Input select chooses the sensor source.
// - Filter enable bypasses or uses the filter.
// - Three-bit field sets filter sample rate.
// - Compare count sets needed matching samples.
// - Delay mode resets low, disabling delay.
// - Delay mode low clears both delay buffers.
// - Delay mode high gives timer run to hardware.
package mgh_pkg;

  localparam logic [3:0] ADR_DEAD   = 4'h0;
  localparam logic [3:0] ADR_POL    = 4'h1;
  localparam logic [3:0] ADR_DRIVE  = 4'h2;
  localparam logic [3:0] ADR_HMODE  = 4'h3;
  localparam logic [3:0] ADR_FILT   = 4'h4;
  localparam logic [3:0] ADR_CHECK  = 4'h5;
  localparam logic [3:0] ADR_STATUS = 4'h6;

  localparam logic [7:0] DEAD_RST   = 8'h00;
  localparam logic [7:0] POL_RST    = 8'h00;
  localparam int         DT_EN_BIT  = 5;
  localparam int         DT_DIV_LSB = 6;
  localparam int         HM_SRC_BIT = 0;
  localparam int         HM_SEL_BIT = 1;
  localparam int         HM_DLY_BIT = 2;
  localparam int         HM_OUT_BIT = 3;
  localparam int         HM_SOFT_LSB = 4;
  localparam int         FL_EN_BIT  = 3;

  typedef enum logic [2:0] {
    DT_IDLE = 3'b001,
    DT_WAIT = 3'b010,
    DT_ON   = 3'b100
  } mgh_dt_state_t;

  typedef struct packed {
    logic [1:0] div_sel;
    logic       enable;
    logic [4:0] count;
  } mgh_dead_cfg_t;

  typedef struct packed {
    logic       req;
    logic [3:0] adr;
    logic       we;
    logic [7:0] dat;
  } mgh_bus_req_t;

  // Tick divider for the dead-time clock.
  function automatic logic div_tick(input logic [1:0] sel, input logic [2:0] cnt);
    logic t;
    t = 1'b0;
    case (sel)
      2'b00:   t = 1'b1;
      2'b01:   t = (cnt[0] == 1'b1);
      2'b10:   t = (cnt[1:0] == 2'h3);
      default: t = (cnt == 3'h7);
    endcase
    return t;
  endfunction : div_tick

endpackage : mgh_pkg

// *** mgh_dead_chan.sv ***
// One channel of rising-edge dead-time insertion.
`timescale 1ns/10ps
module mgh_dead_chan
  import mgh_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Config and tick.
  input  wire mgh_dead_cfg_t cfg_i,
  input  wire logic          tick_i,
  // Drive.
  input  wire logic          req_i,
  output logic               drv_o
);

  mgh_dt_state_t state_ff;
  logic [4:0]    cnt_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= DT_IDLE;
      cnt_ff   <= 5'h00;
    end
    else
    begin
      case (state_ff)
        DT_IDLE:
        begin
          if (req_i && cfg_i.enable)
          begin
            state_ff <= DT_WAIT;
            cnt_ff   <= 5'h00;
          end
          else if (req_i)
            state_ff <= DT_ON;
        end
        DT_WAIT:
        begin
          if (!req_i)
            state_ff <= DT_IDLE;
          else if (tick_i && cnt_ff == cfg_i.count)
            state_ff <= DT_ON;
          else if (tick_i)
            cnt_ff <= cnt_ff + 5'h01;
        end
        DT_ON:
          if (!req_i)
            state_ff <= DT_IDLE;
        default:
          state_ff <= DT_IDLE;
      endcase
    end
  end

  assign drv_o = req_i && (state_ff == DT_ON);

  a_dead_hold_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == DT_IDLE && req_i && cfg_i.enable) |=> !drv_o)
    else $error("Drive rose without dead interval.");

  a_fall_passes: assert property (@(posedge clk_i) disable iff (rst_i)
    !req_i |-> !drv_o)
    else $error("Drive stayed high after request fell.");

  a_no_dead_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_ff == DT_IDLE && req_i && !cfg_i.enable) ##1 req_i |-> drv_o)
    else $error("Disabled dead time delayed the drive.");

endmodule : mgh_dead_chan

// *** mgh_hall_filt.sv ***
// Hall input noise filter for three lines.
`timescale 1ns/10ps
module mgh_hall_filt
  import mgh_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Config.
  input  wire logic [2:0] rate_i,
  input  wire logic [4:0] need_i,
  // Data.
  input  wire logic [2:0] raw_i,
  output logic [2:0]      filt_o
);

  logic [7:0] pre_ff;
  logic       samp;
  logic [4:0] match_ff [3];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_ff <= 8'h00;
    else
      pre_ff <= pre_ff + 8'h01;
  end

  // Sample period is 2 to the rate.
  assign samp = ((pre_ff & ((8'h01 << rate_i) - 8'h01)) == 8'h00);

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_line
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          match_ff[g] <= 5'h00;
          filt_o[g]   <= 1'b0;
        end
        else if (samp)
        begin
          if (raw_i[g] == filt_o[g])
            match_ff[g] <= 5'h00;
          else if (match_ff[g] + 5'h01 >= need_i)
          begin
            filt_o[g]   <= raw_i[g];
            match_ff[g] <= 5'h00;
          end
          else
            match_ff[g] <= match_ff[g] + 5'h01;
        end
      end
    end
  endgenerate

endmodule : mgh_hall_filt

// *** mgh_partner.sv ***
// Model of the Hall sensors and the borrowed delay timer.
`timescale 1ns/10ps
module mgh_partner #(
  parameter int CMP_A = 20
) (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Commanded sensor levels.
  input  wire logic [2:0] hall_set_i,
  input  wire logic [2:0] alt_set_i,
  // Timer handshake and sensor outputs.
  input  wire logic       timer_run_bit_i,
  output logic [2:0]      hall_o,
  output logic [2:0]      alt_o,
  output logic            timer_match_o
);
  logic [7:0] cnt_ff;
  assign hall_o = hall_set_i;
  assign alt_o  = alt_set_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !timer_run_bit_i || timer_match_o)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + 8'h01;
  end
  assign timer_match_o = timer_run_bit_i && (cnt_ff == CMP_A[7:0]);
endmodule : mgh_partner

// *** mgh_top_test.sv ***
// Self-checking bench of the gate conditioning and Hall front end.
`timescale 1ns/10ps
module mgh_top_test;
  import mgh_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, run, match;
  logic [5:0]  adr, gate, oe_n;
  logic [31:0] dat_w, dat_r;
  logic [2:0]  hall_set, alt_set, hs, ha, hall;
  logic [1:0]  tsel;
  logic [7:0]  rd;
  int          n_mismatch, compares, cycles;

  mgh_top mgh_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .gate_o(gate),
    .gate_oe_n_o(oe_n), .hall_sensor_inputs_i(hs), .hall_alt_inputs_i(ha), .hall_out_o(hall),
    .timer_run_bit_o(run), .delay_timer_select_o(tsel), .timer_match_i(match));
  mgh_partner mgh_partner_i (.clk_i(clk_i), .rst_i(rst_i), .hall_set_i(hall_set),
    .alt_set_i(alt_set), .timer_run_bit_i(run), .hall_o(hs), .alt_o(ha),
    .timer_match_o(match));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  // One classic cycle; ends one idle edge after the ack.
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {a, 2'b00};
    dat_w <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic t_reset();
    check("oe_n", 8'(oe_n), 8'h3F);
    check("gate", 8'(gate), 8'h00);
    check("tsel", 8'(tsel), 8'h00);
    wb(0, ADR_DEAD, 8'h00);
    check("dead", rd, DEAD_RST);
    wb(0, ADR_STATUS, 8'h00);
    check("status", rd, 8'h00);
    wb(0, 4'hF, 8'h00);
    check("unmapped", rd, 8'h00);
    wb(1, ADR_POL, 8'hFF);
    wb(0, ADR_POL, 8'h00);
    check("pol", rd, 8'h3F);
    wb(1, ADR_HMODE, 8'h08);
    wt(3);
    check("oe_n on", 8'(oe_n), 8'h00);
    check("gate inv", 8'(gate), 8'h3F);
    $display("done reset");
  endtask : t_reset

  task automatic t_pass();
    wb(1, ADR_POL, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wb(1, ADR_DRIVE, 8'(1 << i));
      wt(3);
      check("rise", 8'(gate), 8'(1 << i));
      wb(1, ADR_DRIVE, 8'h00);
      wt(1);
      check("fall", 8'(gate), 8'h00);
    end
    for (int p = 0; p < 3; p++)
    begin
      wb(1, ADR_DRIVE, 8'(3 << (2 * p)));
      wt(4);
      check("overlap", 8'(gate), 8'h00);
    end
    wb(1, ADR_DRIVE, 8'h15);
    wt(4);
    check("highs", 8'(gate), 8'h15);
    wb(1, ADR_POL, 8'h03);
    wb(1, ADR_DRIVE, 8'h03);
    wt(4);
    check("order", 8'(gate), 8'h03);
    wb(1, ADR_POL, 8'h00);
    wb(1, ADR_DRIVE, 8'h00);
    $display("done pass");
  endtask : t_pass

  task automatic t_dead();
    int iv;
    // Four ticks of 0.1 to 0.8 us stay inside 0.3 to 5 us.
    for (int d = 0; d < 4; d++)
    begin
      // The free divider phase lets the first tick come early, so only three full periods are sure.
      iv = 3 << d;
      wb(1, ADR_DEAD, {2'(d), 1'b1, 5'h03});
      wb(0, ADR_DEAD, 8'h00);
      check("dead rw", rd, {2'(d), 1'b1, 5'h03});
      wb(1, ADR_DRIVE, 8'h01);
      wt(iv);
      check("dead low", 8'(gate), 8'h00);
      wt((1 << d) + 4);
      check("dead high", 8'(gate), 8'h01);
      wb(1, ADR_DRIVE, 8'h00);
      wt(1);
      check("dead fall", 8'(gate), 8'h00);
    end
    wb(1, ADR_DEAD, 8'h00);
    $display("done dead");
  endtask : t_dead

  task automatic t_hall();
    wb(1, ADR_HMODE, 8'h58);
    wt(6);
    check("soft", 8'(hall), 8'h05);
    hall_set <= 3'h3;
    alt_set  <= 3'h6;
    wb(1, ADR_HMODE, 8'h0B);
    wt(6);
    check("alt", 8'(hall), 8'h06);
    wb(1, ADR_HMODE, 8'h09);
    wb(1, ADR_FILT, 8'h08);
    wb(1, ADR_CHECK, 8'h0A);
    wt(20);
    check("sensor", 8'(hall), 8'h03);
    hall_set <= 3'h4;
    wt(5);
    check("filt hold", 8'(hall), 8'h03);
    wt(20);
    check("filt pass", 8'(hall), 8'h04);
    wb(1, ADR_FILT, 8'h00);
    hall_set <= 3'h2;
    wt(5);
    check("bypass", 8'(hall), 8'h02);
    wb(1, ADR_CHECK, 8'h03);
    wt(4);
    wb(1, ADR_FILT, 8'h0A);
    hall_set <= 3'h5;
    wt(6);
    check("rate hold", 8'(hall), 8'h02);
    wt(20);
    check("rate pass", 8'(hall), 8'h05);
    wb(1, ADR_FILT, 8'h00);
    $display("done hall");
  endtask : t_hall

  task automatic t_delay();
    wb(1, ADR_HMODE, 8'h8D);
    hall_set <= 3'h1;
    wt(5);
    check("tsel on", 8'(tsel), 8'h01);
    check("run on", 8'(run), 8'h01);
    check("held", 8'(hall), 8'h00);
    wt(30);
    check("delayed", 8'(hall), 8'h01);
    check("run off", 8'(run), 8'h00);
    wb(1, ADR_HMODE, 8'h09);
    wb(0, ADR_STATUS, 8'h00);
    check("buf clr", 8'(rd[4:2]), 8'h00);
    check("tsel off", 8'(tsel), 8'h00);
    hall_set <= 3'h6;
    wt(6);
    check("no delay", 8'(hall), 8'h06);
    check("no run", 8'(run), 8'h00);
    $display("done delay");
  endtask : t_delay

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial
  begin
    rst_i    = 1'b1;
    cyc      = 1'b0;
    stb      = 1'b0;
    we       = 1'b0;
    adr      = 6'h00;
    dat_w    = 32'h00000000;
    hall_set = 3'h0;
    alt_set  = 3'h0;
    wt(4);
    rst_i <= 1'b0;
    wt(1);
    t_reset();
    t_pass();
    t_dead();
    t_hall();
    t_delay();
    give_verdict();
  end
endmodule : mgh_top_test
